// [logic/lpdl_cfg.svh]
// Constants for the loop phase detector and lock indicator
`ifndef LPDL_CFG_SVH
`define LPDL_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define LPDL_CLK_PERIOD_NS 50
`define LPDL_WINDOW_NS 1500
`define LPDL_WINDOW_CYC ((`LPDL_WINDOW_NS) / (`LPDL_CLK_PERIOD_NS))
`define LPDL_DELAY_NS 200
`define LPDL_DELAY_CYC ((`LPDL_DELAY_NS) / (`LPDL_CLK_PERIOD_NS))

// ----------------------------------------
// Divider ratio and lock reset
// ----------------------------------------
`define LPDL_RATIO_BASE 40
`define LPDL_RATIO_FIXED 35
`define LPDL_RATIO_STROBE 4
`define LPDL_LOCK_RESET 1'b0

`endif

// [logic/lpdl_pkg.sv]
// Types for the loop phase detector and lock indicator
package lpdl_pkg;
	typedef enum logic [2:0]
	{
		LPDL_IDLE = 3'b001,
		LPDL_WINDOW = 3'b010,
		LPDL_DONE = 3'b100
	} lpdl_win_state_t;
	typedef logic [4:0] lpdl_mhz_t;
	typedef logic [6:0] lpdl_ratio_t;
endpackage

// [logic/lpdl_delay_if.sv]
// Carrier between the detector core and its delay lines
`timescale 1ns/1ns
`default_nettype none
interface lpdl_delay_if;
	logic fast_in;
	logic slow_in;
	logic fast_out;
	logic slow_out;
	modport core (output fast_in, output slow_in, input fast_out, input slow_out);
	modport line (input fast_in, input slow_in, output fast_out, output slow_out);
endinterface
`default_nettype wire

// [logic/lpdl_delay.sv]
// Fixed shift delay of the detector true outputs
`timescale 1ns/1ns
`default_nettype none
`include "lpdl_cfg.svh"
module lpdl_delay
#(
	parameter int DEPTH = `LPDL_DELAY_CYC
)
(
	input wire logic clk,
	input wire logic arst_n,
	lpdl_delay_if.line dl
);
	logic [DEPTH-1:0] fast_reg;
	logic [DEPTH-1:0] slow_reg;
	logic [DEPTH-1:0] fast_next;
	logic [DEPTH-1:0] slow_next;

	generate
		if (DEPTH > 1)
		begin : g_long
			assign fast_next = {fast_reg[DEPTH-2:0], dl.fast_in};
			assign slow_next = {slow_reg[DEPTH-2:0], dl.slow_in};
		end
		else
		begin : g_short
			assign fast_next = dl.fast_in;
			assign slow_next = dl.slow_in;
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fast_reg <= '0;
			slow_reg <= '0;
		end
		else
		begin
			fast_reg <= fast_next;
			slow_reg <= slow_next;
		end
	end

	assign dl.fast_out = fast_reg[DEPTH-1];
	assign dl.slow_out = slow_reg[DEPTH-1];

	a_delay_fast: assert property (@(posedge clk) disable iff (!arst_n)
		dl.fast_in |-> ##DEPTH dl.fast_out)
		else $error("fast delay line lost pulse");
	a_delay_slow: assert property (@(posedge clk) disable iff (!arst_n)
		!dl.slow_in |-> ##DEPTH !dl.slow_out)
		else $error("slow delay line invented pulse");
endmodule
`default_nettype wire

// [logic/lpdl_top.sv]
// Phase-frequency detector with fast-lock boost and lock flag
`timescale 1ns/1ns
`default_nettype none
`include "lpdl_cfg.svh"
module lpdl_top
#(
	parameter int WINDOW_CYC = `LPDL_WINDOW_CYC,
	parameter int DELAY_CYC = `LPDL_DELAY_CYC
)
(
	input wire logic MCLK,
	input wire logic ARST_N,
	input wire logic DIV_PULSE,
	input wire logic REF_OSC,
	input wire lpdl_pkg::lpdl_mhz_t MHZ_SETTING,
	output logic LOWER_DRIVE,
	output logic RAISE_DRIVE,
	output logic LOWER_BOOST,
	output logic RAISE_BOOST,
	output logic IN_LOCK,
	output lpdl_pkg::lpdl_ratio_t LOOP_DIVISION_RATIO
);
	import lpdl_pkg::*;

	// ----------------------------------------
	// Edge detection and reference halver
	// ----------------------------------------
	logic div_d_reg;
	logic ref_d_reg;
	logic halver_reg;
	logic halver_d_reg;
	logic div_rise;
	logic ref_osc_rise;
	logic ref_rise;

	assign div_rise = DIV_PULSE && !div_d_reg;
	assign ref_osc_rise = REF_OSC && !ref_d_reg;
	assign ref_rise = halver_reg && !halver_d_reg;

	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			div_d_reg <= 1'b0;
			ref_d_reg <= 1'b0;
			halver_reg <= 1'b0;
			halver_d_reg <= 1'b0;
		end
		else
		begin
			div_d_reg <= DIV_PULSE;
			ref_d_reg <= REF_OSC;
			halver_reg <= halver_reg ^ ref_osc_rise;
			halver_d_reg <= halver_reg;
		end
	end

	// ----------------------------------------
	// Detector flop pair
	// ----------------------------------------
	logic fast_reg;
	logic slow_reg;
	logic fast_next;
	logic slow_next;
	logic clear_both;

	// Both set this cycle: clear at once, so coincidence yields no pulse
	assign clear_both = (fast_reg || div_rise) && (slow_reg || ref_rise);
	assign fast_next = clear_both ? 1'b0 : (fast_reg || div_rise);
	assign slow_next = clear_both ? 1'b0 : (slow_reg || ref_rise);

	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			fast_reg <= 1'b0;
			slow_reg <= 1'b0;
		end
		else
		begin
			fast_reg <= fast_next;
			slow_reg <= slow_next;
		end
	end

	// ----------------------------------------
	// Window one-shot
	// ----------------------------------------
	localparam int WBITS = $clog2(WINDOW_CYC + 1);
	lpdl_win_state_t win_reg;
	lpdl_win_state_t win_next;
	logic [WBITS-1:0] wcnt_reg;
	logic [WBITS-1:0] wcnt_next;
	logic trigger;
	logic window_on;
	logic window_end;
	logic window_done;

	// Falling inverted output equals rising true output
	assign trigger = fast_next && !fast_reg || slow_next && !slow_reg;
	assign window_on = (win_reg == LPDL_WINDOW);
	assign window_end = window_on && (wcnt_reg == WBITS'(WINDOW_CYC - 1));
	// First cycle with the window closed, where the gates become valid
	assign window_done = (win_reg == LPDL_DONE);

	always_comb
	begin
		win_next = win_reg;
		wcnt_next = wcnt_reg;
		case (win_reg)
			LPDL_IDLE:
			begin
				if (trigger)
				begin
					win_next = LPDL_WINDOW;
					wcnt_next = '0;
				end
			end
			LPDL_WINDOW:
			begin
				wcnt_next = wcnt_reg + WBITS'(1);
				if (window_end)
					win_next = LPDL_DONE;
			end
			LPDL_DONE:
			begin
				win_next = LPDL_IDLE;
				if (trigger)
				begin
					win_next = LPDL_WINDOW;
					wcnt_next = '0;
				end
			end
			default:
				win_next = LPDL_IDLE;
		endcase
	end

	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			win_reg <= LPDL_IDLE;
			wcnt_reg <= '0;
		end
		else
		begin
			win_reg <= win_next;
			wcnt_reg <= wcnt_next;
		end
	end

	// ----------------------------------------
	// Delayed pulses and fast-lock gates
	// ----------------------------------------
	lpdl_delay_if dl ();
	assign dl.fast_in = fast_reg;
	assign dl.slow_in = slow_reg;

	lpdl_delay #(.DEPTH(DELAY_CYC)) u_delay
	(
		.clk(MCLK),
		.arst_n(ARST_N),
		.dl(dl)
	);

	logic gate_fast_n;
	logic gate_slow_n;

	// Gate low when delayed pulse still high once window is over
	assign gate_fast_n = !(dl.fast_out && !window_on);
	assign gate_slow_n = !(dl.slow_out && !window_on);

	// ----------------------------------------
	// Lock flag flop
	// ----------------------------------------
	logic lock_q_reg;
	logic lock_q_next;

	// Clocked as the window closes; a gate is never low inside the window
	assign lock_q_next = !gate_fast_n ? 1'b1 :
		(window_done ? !gate_slow_n : lock_q_reg);

	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
			lock_q_reg <= `LPDL_LOCK_RESET;
		else
			lock_q_reg <= lock_q_next;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic lower_reg;
	logic raise_reg;
	logic lboost_reg;
	logic rboost_reg;
	lpdl_ratio_t ratio_reg;

	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			lower_reg <= 1'b0;
			raise_reg <= 1'b0;
			lboost_reg <= 1'b0;
			rboost_reg <= 1'b0;
			ratio_reg <= lpdl_ratio_t'(`LPDL_RATIO_BASE);
		end
		else
		begin
			lower_reg <= fast_next;
			raise_reg <= slow_next;
			lboost_reg <= !gate_fast_n;
			rboost_reg <= !gate_slow_n;
			ratio_reg <= lpdl_ratio_t'(`LPDL_RATIO_BASE) + lpdl_ratio_t'(MHZ_SETTING);
		end
	end

	assign LOWER_DRIVE = lower_reg;
	assign RAISE_DRIVE = raise_reg;
	assign LOWER_BOOST = lboost_reg;
	assign RAISE_BOOST = rboost_reg;
	assign IN_LOCK = !lock_q_reg;
	assign LOOP_DIVISION_RATIO = ratio_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [WBITS-1:0] win_len_reg;
	logic [WBITS-1:0] win_len_next;

	// Cycles the window has stood so far
	assign win_len_next = window_on ? win_len_reg + WBITS'(1) : '0;

	always_ff @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
			win_len_reg <= '0;
		else
			win_len_reg <= win_len_next;
	end

	a_clear_both: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!(fast_reg && slow_reg))
		else $error("both detector flops high together");
	a_div_sets: assert property (@(posedge MCLK) disable iff (!ARST_N)
		div_rise && !slow_reg && !ref_rise |=> fast_reg)
		else $error("divider edge did not set flop");
	a_ref_sets: assert property (@(posedge MCLK) disable iff (!ARST_N)
		ref_rise && !fast_reg && !div_rise |=> slow_reg)
		else $error("reference edge did not set flop");
	a_halver_toggle: assert property (@(posedge MCLK) disable iff (!ARST_N)
		ref_osc_rise |=> halver_reg != $past(halver_reg))
		else $error("reference halver did not toggle");
	a_lower_follows: assert property (@(posedge MCLK) disable iff (!ARST_N)
		fast_reg && ref_rise |=> !LOWER_DRIVE && !RAISE_DRIVE)
		else $error("lower drive not ended by reference edge");
	a_raise_follows: assert property (@(posedge MCLK) disable iff (!ARST_N)
		slow_reg && div_rise |=> !RAISE_DRIVE && !LOWER_DRIVE)
		else $error("raise drive not ended by divider edge");
	a_coincide_quiet: assert property (@(posedge MCLK) disable iff (!ARST_N)
		div_rise && ref_rise && !fast_reg && !slow_reg |=> !LOWER_DRIVE && !RAISE_DRIVE)
		else $error("coincident edges gave correction");
	a_window_start: assert property (@(posedge MCLK) disable iff (!ARST_N)
		trigger && !window_on |=> window_on)
		else $error("window not started");
	a_window_len: assert property (@(posedge MCLK) disable iff (!ARST_N)
		$fell(window_on) |-> win_len_reg == WBITS'(WINDOW_CYC))
		else $error("window length wrong");
	a_window_max: assert property (@(posedge MCLK) disable iff (!ARST_N)
		win_len_reg <= WBITS'(WINDOW_CYC))
		else $error("window overran its length");
	a_preset_unlock: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!gate_fast_n |=> !IN_LOCK)
		else $error("fast gate did not force unlock");
	a_fast_boost: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!gate_fast_n |=> LOWER_BOOST)
		else $error("lower boost missing");
	a_slow_boost: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!gate_slow_n |=> RAISE_BOOST)
		else $error("raise boost missing");
	a_slow_unlock: assert property (@(posedge MCLK) disable iff (!ARST_N)
		window_done && !gate_slow_n |=> !IN_LOCK)
		else $error("slow gate did not unlock");
	a_lock_set: assert property (@(posedge MCLK) disable iff (!ARST_N)
		window_done && gate_slow_n && gate_fast_n |=> IN_LOCK)
		else $error("lock not flagged");
	a_lock_hold: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!window_done && gate_fast_n |=> IN_LOCK == $past(IN_LOCK))
		else $error("lock flag changed between window ends");
	a_ratio: assert property (@(posedge MCLK) disable iff (!ARST_N)
		##1 LOOP_DIVISION_RATIO ==
			lpdl_ratio_t'(`LPDL_RATIO_BASE) + lpdl_ratio_t'($past(MHZ_SETTING)))
		else $error("division ratio wrong");

	c_lower: cover property (@(posedge MCLK) disable iff (!ARST_N) $rose(LOWER_BOOST));
	c_raise: cover property (@(posedge MCLK) disable iff (!ARST_N) $rose(RAISE_BOOST));
	c_lock: cover property (@(posedge MCLK) disable iff (!ARST_N) $rose(IN_LOCK));
	c_coincide: cover property (@(posedge MCLK) disable iff (!ARST_N) div_rise && ref_rise);
	c_slow_unlock: cover property (@(posedge MCLK) disable iff (!ARST_N) window_done && !gate_slow_n);
endmodule
`default_nettype wire

// [testbench/lpdl_loop_model.sv]
// Far-side model: programmed divider and reference oscillator edges
`timescale 1ns/1ns
`default_nettype none
module lpdl_loop_model
(
	input wire logic clk,
	output logic div_pulse,
	output logic ref_osc
);
	logic halver;
	initial
	begin
		div_pulse = 1'b0;
		ref_osc = 1'b0;
		halver = 1'b0;
	end
	// Lower both lines; bring the halver back to 0 without a reference edge
	task automatic arm();
		div_pulse = 1'b0;
		ref_osc = 1'b0;
		repeat (2) @(negedge clk);
		if (halver)
		begin
			ref_osc = 1'b1;
			halver = 1'b0;
			repeat (2) @(negedge clk);
			ref_osc = 1'b0;
			repeat (2) @(negedge clk);
		end
	endtask
	// Positive-going divider pulse and halver-raising oscillator rise
	task automatic fire(input logic d, input logic r);
		if (d)
			div_pulse = 1'b1;
		if (r)
		begin
			ref_osc = 1'b1;
			halver = ~halver;
		end
	endtask
endmodule
`default_nettype wire

// [testbench/loop_phase_detector_lock_tb.sv]
// Self-checking bench for the phase detector and lock flag
`timescale 1ns/1ns
`default_nettype none
module loop_phase_detector_lock_tb;
	import lpdl_pkg::*;
	localparam int WIN = 10;
	localparam int DLY = 2;
	logic MCLK = 1'b0;
	logic ARST_N = 1'b0;
	logic DIV_PULSE, REF_OSC, LOWER_DRIVE, RAISE_DRIVE, LOWER_BOOST, RAISE_BOOST, IN_LOCK;
	lpdl_mhz_t MHZ_SETTING = 5'h00;
	lpdl_ratio_t LOOP_DIVISION_RATIO;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	logic seen_ld, seen_rd, seen_lb, seen_rb, seen_unl, early;
	always #25 MCLK = ~MCLK;
	lpdl_top #(.WINDOW_CYC(WIN), .DELAY_CYC(DLY)) uut (.MCLK(MCLK), .ARST_N(ARST_N),
		.DIV_PULSE(DIV_PULSE), .REF_OSC(REF_OSC), .MHZ_SETTING(MHZ_SETTING),
		.LOWER_DRIVE(LOWER_DRIVE), .RAISE_DRIVE(RAISE_DRIVE), .LOWER_BOOST(LOWER_BOOST),
		.RAISE_BOOST(RAISE_BOOST), .IN_LOCK(IN_LOCK), .LOOP_DIVISION_RATIO(LOOP_DIVISION_RATIO));
	lpdl_loop_model model (.clk(MCLK), .div_pulse(DIV_PULSE), .ref_osc(REF_OSC));
	// ----------------------------------------
	// Activity monitor and timeout
	// ----------------------------------------
	always @(posedge MCLK)
	begin
		cycles++;
		seen_ld |= LOWER_DRIVE;
		seen_rd |= RAISE_DRIVE;
		seen_lb |= LOWER_BOOST;
		seen_rb |= RAISE_BOOST;
		seen_unl |= ~IN_LOCK;
		if (cycles == 3000)
		begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (num_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [6:0] exp, input logic [6:0] got);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge MCLK);
	endtask
	// Mode 0 divider first, 1 reference first, 2 coincident
	task automatic run_pair(input int mode, input int gap);
		model.arm();
		cyc(WIN + 6);
		{seen_ld, seen_rd, seen_lb, seen_rb, seen_unl} = '0;
		if (mode == 2)
		begin
			model.fire(1'b0, 1'b1);
			cyc(1);
			model.fire(1'b1, 1'b0);
		end
		else
		begin
			model.fire(mode == 0, mode == 1);
			cyc(3);
			early = (mode == 0) ? LOWER_DRIVE : RAISE_DRIVE;
			cyc(gap - 3);
			model.fire(mode == 1, mode == 0);
		end
		cyc(WIN + DLY + 8);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_reset();
		chk("lower", 0, {LOWER_DRIVE, RAISE_DRIVE, LOWER_BOOST, RAISE_BOOST});
		chk("lock", 1, IN_LOCK);
		chk("ratio", 40, LOOP_DIVISION_RATIO);
	endtask
	task automatic s_ratio();
		int vals[5] = '{0, 7, 14, 21, 29};
		foreach (vals[i])
		begin
			MHZ_SETTING = 5'(vals[i]);
			cyc(2);
			chk("ratio", 7'(40 + vals[i]), LOOP_DIVISION_RATIO);
		end
	endtask
	task automatic s_div_first();
		run_pair(0, 4);
		chk("lower", 1, early);
		chk("raise", 0, seen_rd);
		chk("drives", 0, {LOWER_DRIVE, RAISE_DRIVE});
		chk("boost", 0, {seen_lb, seen_rb});
		chk("lock", 1, IN_LOCK);
	endtask
	task automatic s_ref_first();
		run_pair(1, 4);
		chk("raise", 1, early);
		chk("lower", 0, seen_ld);
		chk("drives", 0, {LOWER_DRIVE, RAISE_DRIVE});
		chk("lock", 1, IN_LOCK);
	endtask
	task automatic s_coincide();
		run_pair(2, 0);
		chk("drives", 0, {seen_ld, seen_rd});
	endtask
	task automatic s_fast_out();
		run_pair(0, 20);
		chk("lboost", 1, seen_lb);
		chk("rboost", 0, seen_rb);
		chk("unlock", 1, seen_unl);
		run_pair(0, 4);
		chk("lock", 1, IN_LOCK);
	endtask
	task automatic s_slow_out();
		run_pair(1, 20);
		chk("rboost", 1, seen_rb);
		chk("lboost", 0, seen_lb);
		run_pair(1, 20);
		chk("unlock", 1, seen_unl);
		run_pair(1, 4);
		chk("lock", 1, IN_LOCK);
	endtask
	initial
	begin
		cyc(5);
		s_reset();
		ARST_N = 1'b1;
		s_ratio();
		s_div_first();
		s_ref_first();
		s_coincide();
		s_fast_out();
		s_slow_out();
		report_and_stop();
	end
endmodule
`default_nettype wire
